// *** src/ect_map.svh ***
// Numeric constants of the event capture timer: bounds, reset values, counts.
// Assumes it is included by bare name wherever these values are used.
`ifndef ECT_MAP_SVH
`define ECT_MAP_SVH

// The counter is at BOTTOM when it holds all zeros.
`define ECT_BOTTOM 16'h0000
// The counter is at MAX when it holds all ones.
`define ECT_MAX 16'hFFFF
// One count step.
`define ECT_STEP 16'h0001
// Count register value after reset.
`define ECT_COUNT_RESET 16'h0000
// Compare capture register value after reset.
`define ECT_CAPVAL_RESET 16'h0000
// Divide ratio of the divided peripheral clock tap.
`define ECT_PRESC_DIV 2

`endif

// *** src/ect_pkg.sv ***
// Types shared by the event capture timer and its helpers.
// Assumes numeric values come from ect_map.svh, not from this package.
package ect_pkg;

  // Operating modes; the first one is the mode taken after reset.
  typedef enum logic [2:0] {
    ECT_MODE_PERIODIC,
    ECT_MODE_TIMEOUT,
    ECT_MODE_EVENT_CAP,
    ECT_MODE_FREQ,
    ECT_MODE_PW,
    ECT_MODE_FREQ_PW,
    ECT_MODE_SINGLE,
    ECT_MODE_PWM8
  } ect_mode_e;

  // Clock source select: peripheral clock, divided tap, companion timer ticks.
  typedef enum logic [1:0] {
    ECT_PERIPHERAL_CLOCK,
    ECT_PERIPHERAL_CLOCK_DIV,
    ECT_CLK_COMPANION,
    ECT_CLK_NONE
  } ect_clk_sel_e;

  // Progress of a measurement sequence.
  typedef enum logic [1:0] {
    ECT_PH_IDLE,
    ECT_PH_WAIT_FALL,
    ECT_PH_WAIT_RISE,
    ECT_PH_DONE
  } ect_phase_e;

  // Configuration levels held by software.
  typedef struct packed {
    logic enable;
    ect_clk_sel_e clock_source_select;
    ect_mode_e mode;
    logic edge_sel;
  } ect_ctrl_s;

  // One-cycle software access strobes with their data.
  typedef struct packed {
    logic count_wr;
    logic [15:0] count_wdata;
    logic cap_wr;
    logic [15:0] cap_wdata;
    logic cap_low_rd;
    logic flag_clr;
    logic run_wr;
    logic run_wdata;
  } ect_sw_s;

  // Whole state of the timer core.
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] cap_val;
    logic flag;
    logic evt;
    logic run;
    ect_phase_e phase;
    ect_mode_e mode;
  } ect_state_s;

endpackage

// *** src/ect_tick_sel.sv ***
// Counter clock selection: turns the chosen source into a one-cycle tick.
// Assumes the companion tick is a pulse from logic on the same clock.
`timescale 1ns/1ps
`include "ect_map.svh"
module ect_tick_sel
  import ect_pkg::*;
#(
  parameter int unsigned PRESC_DIV = `ECT_PRESC_DIV
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Source choice and companion tick.
  input wire ect_clk_sel_e clock_source_select_i,
  input wire logic companion_tick_i,
  // Selected tick.
  output logic tick_o
);
  localparam int unsigned DIV_W = $clog2(PRESC_DIV);

  // A divider shorter than two would make the divided tap a plain clock.
  if (PRESC_DIV < 2) begin : g_chk
    $error("Prescaler divide must be at least two.");
  end

  // Divider phase and registered tick.
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic tick;
  } ect_tick_state_s;

  ect_tick_state_s st_reg;  // Registered state.
  ect_tick_state_s st_next;  // Next state.

  // The divider runs freely so that the divided tap keeps a steady rate.
  always_comb begin
    st_next = st_reg;
    st_next.div = (st_reg.div == DIV_W'(PRESC_DIV - 1)) ? '0 : st_reg.div + DIV_W'(1);
    case (clock_source_select_i)
      ECT_PERIPHERAL_CLOCK: st_next.tick = 1'b1;  // RULE2
      ECT_PERIPHERAL_CLOCK_DIV: st_next.tick = (st_reg.div == DIV_W'(PRESC_DIV - 1));  // RULE2
      ECT_CLK_COMPANION: st_next.tick = companion_tick_i;  // RULE3
      default: st_next.tick = 1'b0;
    endcase
  end

  // State register.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_o = st_reg.tick;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // The divided tap never ticks on two edges in a row.
  property p_rule2;
    (clock_source_select_i == ECT_PERIPHERAL_CLOCK_DIV && tick_o) ##1
    (clock_source_select_i == ECT_PERIPHERAL_CLOCK_DIV) |-> !tick_o;
  endproperty
  a_rule2: assert property (p_rule2) else $error("Divided tap ticked twice.");  // RULE2

  // The companion tick is followed one edge later.
  property p_rule3;
    clock_source_select_i == ECT_CLK_COMPANION |=> tick_o == $past(companion_tick_i);
  endproperty
  a_rule3: assert property (p_rule3) else $error("Tick not in step with companion.");  // RULE3
endmodule

// *** src/ect_edge_det.sv ***
// Event input synchroniser and edge detector.
// Assumes each event level is held longer than one clock cycle by its source.
`timescale 1ns/1ps
module ect_edge_det (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Event level from the routing network.
  input wire logic event_i,
  // One-cycle edge pulses.
  output logic rise_o,
  output logic fall_o
);
  // Two synchroniser stages, the previous level and the edge pulses.
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic rise;
    logic fall;
  } ect_edge_state_s;

  ect_edge_state_s st_reg;  // Registered state.
  ect_edge_state_s st_next;  // Next state.

  // Only the second stage feeds the comparison, never the first.
  always_comb begin
    st_next = st_reg;
    st_next.sync1 = event_i;
    st_next.sync2 = st_reg.sync1;
    st_next.prev = st_reg.sync2;
    st_next.rise = st_reg.sync2 & ~st_reg.prev;
    st_next.fall = ~st_reg.sync2 & st_reg.prev;
  end

  // State register.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rise_o = st_reg.rise;
  assign fall_o = st_reg.fall;
endmodule

// *** src/ect_timer.sv ***
// Sixteen-bit event capture timer core with its mode control.
// Assumes software strobes and the companion tick come from the same clock;
// the event level may come from anywhere and is synchronised here.
`timescale 1ns/1ps
`include "ect_map.svh"
// Operation
// RULE1 - Zero is BOTTOM, all ones MAX.
// RULE2 - Clock source select picks the counter tick.
// RULE3 - Companion clock keeps counter in step.
// RULE4 - Reset leaves periodic mode; eight modes exist.
// RULE5 - Enable starts counting selected ticks.
// RULE6 - Periodic: reach compare value, flag, restart.
// RULE7 - Compare below count: run to MAX, wrap.
// RULE8 - Event source holds pulses beyond one cycle.
// RULE9 - Time-out: first edge starts, next stops.
// RULE10 - Time-out: flag when TOP reached first.
// RULE11 - Frozen time-out restarts on new start edge.
// RULE12 - Frozen: reads and run writes do nothing.
// RULE13 - Event capture: free run, copy on event.
// RULE14 - Capture edge polarity is selectable.
// RULE15 - Low byte read clears flag in capture.
// RULE16 - Software zeroes count entering event capture.
// RULE17 - Frequency: capture and restart each edge.
// RULE18 - Pulse width: restart rise, capture fall.
// RULE19 - Edges alternate; source spaces them two cycles.
// RULE20 - Capture event matches flag set exactly.
// RULE21 - Running counter adds one per tick.
module ect_timer
  import ect_pkg::*;
#(
  parameter int unsigned PRESC_DIV = `ECT_PRESC_DIV
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Configuration levels.
  input wire ect_ctrl_s ctrl_i,
  // Software access strobes.
  input wire ect_sw_s sw_i,
  // Tick of the companion timer.
  input wire logic companion_tick_i,
  // Event level from the routing network.
  input wire logic event_i,
  // Counter and capture values.
  output logic [15:0] count_value_o,
  output logic [15:0] compare_capture_value_o,
  // Status and outgoing event.
  output logic capture_flag_o,
  output logic capture_event_o,
  output logic run_o
);

  ect_state_s st_reg;  // Registered state of the core.
  ect_state_s st_next;  // Next state, built combinationally.
  logic tick_w;  // Selected counter tick.
  logic rise_w;  // Rising event edge pulse.
  logic fall_w;  // Falling event edge pulse.
  logic start_edge;  // Edge chosen by the edge select bit.
  logic stop_edge;  // The opposite edge.
  logic set_flag;  // Hardware sets the capture flag this cycle.
  logic clr_flag;  // Software clears the capture flag this cycle.
  logic mode_same;  // Mode unchanged since the last edge.

  // Add one with natural wrap from MAX to BOTTOM.
  function automatic logic [15:0] count_inc(input logic [15:0] v);
    count_inc = v + `ECT_STEP;
  endfunction

  // True in the modes that capture into the compare capture register.
  function automatic logic is_capture(input ect_mode_e m);
    is_capture = (m == ECT_MODE_EVENT_CAP) || (m == ECT_MODE_FREQ) ||
                 (m == ECT_MODE_PW) || (m == ECT_MODE_FREQ_PW);
  endfunction

  // Counter tick source.
  ect_tick_sel #(
    .PRESC_DIV(PRESC_DIV)
  ) u_tick (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clock_source_select_i(ctrl_i.clock_source_select),  // RULE2
    .companion_tick_i(companion_tick_i),  // RULE3
    .tick_o(tick_w)
  );

  // Event edges, after two synchroniser stages.
  ect_edge_det u_edge (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .event_i(event_i),
    .rise_o(rise_w),
    .fall_o(fall_w)
  );

  // Edge select low means rising edges start or capture; high means falling.
  assign start_edge = ctrl_i.edge_sel ? fall_w : rise_w;  // RULE14
  assign stop_edge = ctrl_i.edge_sel ? rise_w : fall_w;  // RULE9
  assign mode_same = (ctrl_i.mode == st_reg.mode);

  // Software clear by flag write, or by a low byte read in a capture mode.
  // Reads in time-out mode never clear, so a frozen read stays harmless.
  assign clr_flag = sw_i.flag_clr | (sw_i.cap_low_rd & is_capture(ctrl_i.mode));  // RULE15 RULE12

  // Next-state logic for every mode.
  always_comb begin
    st_next = st_reg;
    st_next.evt = 1'b0;
    set_flag = 1'b0;
    st_next.mode = ctrl_i.mode;
    // A software compare write loses against a capture in the same cycle.
    if (sw_i.cap_wr) begin
      st_next.cap_val = sw_i.cap_wdata;
    end
    if (!mode_same) begin
      // A mode change drops any half-done sequence.
      st_next.phase = ECT_PH_IDLE;
      st_next.run = 1'b0;
    end else if (ctrl_i.enable) begin  // RULE5
      case (ctrl_i.mode)
        ECT_MODE_PERIODIC: begin
          if (tick_w) begin
            if (st_reg.count == st_reg.cap_val) begin
              // TOP reached: flag it and restart from BOTTOM.
              st_next.count = `ECT_BOTTOM;  // RULE6 RULE1
              set_flag = 1'b1;  // RULE6
            end else begin
              // A compare value below the count lets it run to MAX and wrap.
              st_next.count = count_inc(st_reg.count);  // RULE7 RULE21
            end
          end
        end
        ECT_MODE_TIMEOUT: begin
          if (!st_reg.run) begin
            // Frozen: only a start edge has an effect.
            if (start_edge) begin
              st_next.run = 1'b1;  // RULE9 RULE11
              st_next.count = `ECT_BOTTOM;  // RULE11
            end
          end else if (stop_edge) begin
            st_next.run = 1'b0;  // RULE9
          end else begin
            // The run bit is writable only while running.
            if (sw_i.run_wr) begin
              st_next.run = sw_i.run_wdata;  // RULE12
            end
            if (tick_w) begin
              st_next.count = count_inc(st_reg.count);  // RULE21
              if (st_reg.count == st_reg.cap_val) begin
                set_flag = 1'b1;  // RULE10
              end
            end
          end
        end
        ECT_MODE_EVENT_CAP: begin
          // Free run from BOTTOM to MAX; a capture does not disturb it.
          if (tick_w) begin
            st_next.count = count_inc(st_reg.count);  // RULE13 RULE21
          end
          if (start_edge) begin
            st_next.cap_val = st_reg.count;  // RULE13 RULE14
            set_flag = 1'b1;  // RULE13
          end
        end
        ECT_MODE_FREQ: begin
          if (start_edge) begin
            st_next.cap_val = st_reg.count;  // RULE17
            st_next.count = `ECT_BOTTOM;  // RULE17
            set_flag = 1'b1;  // RULE17
          end else if (tick_w) begin
            st_next.count = count_inc(st_reg.count);  // RULE21
          end
        end
        ECT_MODE_PW: begin
          // The detector alternates by itself between rise and fall.
          if (rise_w) begin
            st_next.count = `ECT_BOTTOM;  // RULE18
            st_next.phase = ECT_PH_WAIT_FALL;  // RULE19
          end else begin
            if (tick_w) begin
              st_next.count = count_inc(st_reg.count);  // RULE21
            end
            if (fall_w && st_reg.phase == ECT_PH_WAIT_FALL) begin
              st_next.cap_val = st_reg.count;  // RULE18
              st_next.phase = ECT_PH_IDLE;  // RULE19
              set_flag = 1'b1;  // RULE18
            end
          end
        end
        ECT_MODE_FREQ_PW: begin
          case (st_reg.phase)
            ECT_PH_IDLE: begin
              // Wait for the rising edge that opens a period.
              if (rise_w) begin
                st_next.count = `ECT_BOTTOM;
                st_next.phase = ECT_PH_WAIT_FALL;
              end
            end
            ECT_PH_WAIT_FALL: begin
              // The falling edge captures the high time.
              if (tick_w) begin
                st_next.count = count_inc(st_reg.count);
              end
              if (fall_w) begin
                st_next.cap_val = st_reg.count;
                st_next.phase = ECT_PH_WAIT_RISE;
              end
            end
            ECT_PH_WAIT_RISE: begin
              // The second rising edge stops the counter and flags.
              if (rise_w) begin
                st_next.phase = ECT_PH_DONE;
                set_flag = 1'b1;
              end else if (tick_w) begin
                st_next.count = count_inc(st_reg.count);
              end
            end
            ECT_PH_DONE: begin
              // Held until software has consumed the result.
              if (!st_reg.flag) begin
                st_next.phase = ECT_PH_IDLE;
              end
            end
            default: begin
              st_next.phase = ECT_PH_IDLE;
            end
          endcase
        end
        default: begin
          // Single-shot and 8-bit PWM are not served; the counter holds.
          st_next.count = st_reg.count;
        end
      endcase
    end
    // A software count write wins over counting, clearing and reloading.
    if (sw_i.count_wr) begin
      st_next.count = sw_i.count_wdata;
    end
    // Clear first and set last, so an event in the clear cycle survives.
    if (clr_flag) begin
      st_next.flag = 1'b0;
    end
    if (set_flag) begin
      st_next.flag = 1'b1;
      st_next.evt = 1'b1;  // RULE20
    end
  end

  // State register; reset leaves periodic mode with everything cleared.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '{count: `ECT_COUNT_RESET, cap_val: `ECT_CAPVAL_RESET, flag: 1'b0,
                  evt: 1'b0, run: 1'b0, phase: ECT_PH_IDLE,
                  mode: ECT_MODE_PERIODIC};  // RULE4
    end else begin
      st_reg <= st_next;
    end
  end

  // All outputs are fields of the state register.
  assign count_value_o = st_reg.count;
  assign compare_capture_value_o = st_reg.cap_val;
  assign capture_flag_o = st_reg.flag;
  assign capture_event_o = st_reg.evt;
  assign run_o = st_reg.run;

  // Helper: no software strobe in this cycle.
  logic sw_quiet;
  assign sw_quiet = !sw_i.count_wr && !sw_i.cap_wr && !sw_i.flag_clr &&
                    !sw_i.cap_low_rd && !sw_i.run_wr;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Helper: enabled, mode steady, no software strobe.
  sequence s_steady(ect_mode_e m);
    ctrl_i.enable && mode_same && ctrl_i.mode == m && sw_quiet;
  endsequence

  property p_rule1;
    s_steady(ECT_MODE_EVENT_CAP) and (tick_w && count_value_o == `ECT_MAX)
      |=> count_value_o == `ECT_BOTTOM;
  endproperty
  a_rule1: assert property (p_rule1) else $error("MAX did not wrap to BOTTOM.");  // RULE1

  property p_rule4;
    $fell(rst_i) |-> st_reg.mode == ECT_MODE_PERIODIC && !capture_flag_o;
  endproperty
  a_rule4: assert property (p_rule4) else $error("Reset mode is not periodic.");  // RULE4

  property p_rule5;
    !ctrl_i.enable && mode_same && sw_quiet |=> $stable(count_value_o) && !capture_event_o;
  endproperty
  a_rule5: assert property (p_rule5) else $error("Counter moved while disabled.");  // RULE5

  property p_rule6;
    s_steady(ECT_MODE_PERIODIC) and (tick_w && count_value_o == compare_capture_value_o)
      |=> count_value_o == `ECT_BOTTOM && capture_flag_o && capture_event_o;
  endproperty
  a_rule6: assert property (p_rule6) else $error("Periodic match missed.");  // RULE6

  property p_rule7;
    s_steady(ECT_MODE_PERIODIC) and
      (tick_w && count_value_o == `ECT_MAX && compare_capture_value_o != `ECT_MAX)
      |=> count_value_o == `ECT_BOTTOM && !capture_event_o;
  endproperty
  a_rule7: assert property (p_rule7) else $error("Periodic wrap at MAX wrong.");  // RULE7

  property p_rule9;
    s_steady(ECT_MODE_TIMEOUT) and (run_o && stop_edge) |=> !run_o ##1 !run_o || start_edge;
  endproperty
  a_rule9: assert property (p_rule9) else $error("Stop edge did not freeze.");  // RULE9

  property p_rule10;
    s_steady(ECT_MODE_TIMEOUT) and
      (run_o && !stop_edge && tick_w && count_value_o == compare_capture_value_o)
      |=> capture_flag_o && capture_event_o && run_o;
  endproperty
  a_rule10: assert property (p_rule10) else $error("Time-out not flagged.");  // RULE10

  property p_rule11;
    s_steady(ECT_MODE_TIMEOUT) and (!run_o && start_edge)
      |=> run_o && count_value_o == `ECT_BOTTOM;
  endproperty
  a_rule11: assert property (p_rule11) else $error("Frozen timer did not restart.");  // RULE11

  property p_rule12;
    (ctrl_i.enable && mode_same && ctrl_i.mode == ECT_MODE_TIMEOUT && !run_o && !start_edge &&
     !sw_i.count_wr && !sw_i.cap_wr && !sw_i.flag_clr && (sw_i.run_wr || sw_i.cap_low_rd))
      |=> !run_o && $stable(capture_flag_o) && $stable(count_value_o);
  endproperty
  a_rule12: assert property (p_rule12) else $error("Access in freeze had effect.");  // RULE12

  property p_rule13;
    s_steady(ECT_MODE_EVENT_CAP) and start_edge
      |=> compare_capture_value_o == $past(count_value_o) && capture_flag_o && capture_event_o;
  endproperty
  a_rule13: assert property (p_rule13) else $error("Event capture wrong.");  // RULE13

  property p_rule14;
    s_steady(ECT_MODE_EVENT_CAP) and !start_edge |=> !capture_event_o;
  endproperty
  a_rule14: assert property (p_rule14) else $error("Capture on wrong edge.");  // RULE14

  property p_rule15;
    is_capture(ctrl_i.mode) && capture_flag_o && sw_i.cap_low_rd && !set_flag
      |=> !capture_flag_o;
  endproperty
  a_rule15: assert property (p_rule15) else $error("Low byte read kept flag.");  // RULE15

  property p_rule17;
    s_steady(ECT_MODE_FREQ) and start_edge
      |=> count_value_o == `ECT_BOTTOM && compare_capture_value_o == $past(count_value_o);
  endproperty
  a_rule17: assert property (p_rule17) else $error("Frequency capture wrong.");  // RULE17

  // Pulse-width steps: the opening rise, then the closing fall.
  sequence s_pw_rise;
    s_steady(ECT_MODE_PW) and rise_w;
  endsequence
  sequence s_pw_fall;
    s_steady(ECT_MODE_PW) and (fall_w && !rise_w && st_reg.phase == ECT_PH_WAIT_FALL);
  endsequence

  property p_rule18;
    s_pw_rise |=> count_value_o == `ECT_BOTTOM && !capture_event_o;
  endproperty
  a_rule18: assert property (p_rule18) else $error("Pulse-width restart wrong.");  // RULE18

  property p_rule19;
    s_pw_fall |=> st_reg.phase == ECT_PH_IDLE && capture_event_o &&
      compare_capture_value_o == $past(count_value_o);
  endproperty
  a_rule19: assert property (p_rule19) else $error("Pulse-width capture wrong.");  // RULE19

  property p_rule20;
    $rose(capture_flag_o) || capture_event_o |-> capture_flag_o && capture_event_o;
  endproperty
  a_rule20: assert property (p_rule20) else $error("Event and flag disagree.");  // RULE20

  property p_rule21;
    s_steady(ECT_MODE_PERIODIC) and (tick_w && count_value_o != compare_capture_value_o)
      |=> count_value_o == $past(count_value_o) + `ECT_STEP;
  endproperty
  a_rule21: assert property (p_rule21) else $error("Count did not add one.");  // RULE21
endmodule

// *** tb/ect_evt_src.sv ***
// Event routing network model: turns a wanted level into a clean event level.
// Assumes the bench changes the wanted level on rising edges of mclk_i.
`timescale 1ns/1ps
module ect_evt_src (
  // Clock.
  input wire logic mclk_i,
  // Level the bench asks for.
  input wire logic want_i,
  // Event level towards the timer.
  output logic event_o
);
  // Level and cycles since its last change; starts settled and low.
  logic event_reg = 1'b0;
  logic [1:0] held_reg = 2'h3;
  // A change waits until the old level stood four cycles, so pulses are wide.
  always_ff @(posedge mclk_i) begin
    if (want_i != event_reg && held_reg == 2'h3) begin
      event_reg <= want_i;
      held_reg <= 2'h0;
    end else if (held_reg != 2'h3) begin
      held_reg <= held_reg + 2'h1;
    end
  end
  assign event_o = event_reg;
endmodule

// *** tb/testbench.sv ***
// Self-checking bench of the event capture timer core.
// Assumes the event model drives the event level and the bench all else.
`timescale 1ns/1ps
module testbench
  import ect_pkg::*;
;
  // One capture case: set-up, edge level and expected results.
  typedef struct packed {
    ect_mode_e mode;
    logic es;
    logic lvl;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic [15:0] after;
  } ect_row_s;
  // Frequency rows restart the count; event capture leaves it alone.
  ect_row_s rows [4] = '{
    '{ECT_MODE_EVENT_CAP, 1'b0, 1'b1, 16'h1234, 16'h1234, 16'h1234},
    '{ECT_MODE_EVENT_CAP, 1'b1, 1'b0, 16'hA5C3, 16'hA5C3, 16'hA5C3},
    '{ECT_MODE_FREQ, 1'b0, 1'b1, 16'h0055, 16'h0055, 16'h0000},
    '{ECT_MODE_FREQ, 1'b1, 1'b0, 16'hFFFF, 16'hFFFF, 16'h0000}};
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  ect_ctrl_s ctrl = '0;
  ect_sw_s sw = '0;
  logic comp_tick = 1'b0;
  logic want = 1'b0;
  logic evt;
  logic [15:0] cnt_o;
  logic [15:0] cap_o;
  logic flag_o;
  logic cevt_o;
  logic run_o;
  logic [15:0] held;
  int fail_count = 0;
  int checked = 0;
  ect_timer #(.PRESC_DIV(2)) ect_timer_i (.mclk_i(mclk_i), .rst_i(rst_i), .ctrl_i(ctrl),
    .sw_i(sw), .companion_tick_i(comp_tick), .event_i(evt), .count_value_o(cnt_o),
    .compare_capture_value_o(cap_o), .capture_flag_o(flag_o), .capture_event_o(cevt_o),
    .run_o(run_o));
  ect_evt_src ect_evt_src_i (.mclk_i(mclk_i), .want_i(want), .event_o(evt));
  // Clock of 8 ns.
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits n edges, then one nanosecond so the edge's updates have landed.
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // Software strobe: 0 count, 1 compare, 2 low read, 3 flag clear, 4 run.
  task automatic op(input int k, input logic [15:0] v);
    @(posedge mclk_i);
    sw <= '{k == 0, v, k == 1, v, k == 2, k == 3, k == 4, v[0]};
    @(posedge mclk_i);
    sw <= '0;
    #1;
  endtask
  task automatic setc(input ect_clk_sel_e sel, input ect_mode_e m, input logic es);
    @(posedge mclk_i);
    ctrl <= '{1'b1, sel, m, es};
    cyc(2);
  endtask
  task automatic lvl(input logic v);
    @(posedge mclk_i);
    want <= v;
  endtask
  // Bounded wait for the outgoing capture event.
  task automatic wait_evt;
    for (int i = 0; i < 40 && cevt_o !== 1'b1; i++) cyc(1);
    chk(16'(cevt_o), 16'h0001);
  endtask
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles the tests need.
  initial begin
    #100000;
    fail_count++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    cyc(1);
    chk(cnt_o, 16'h0000);
    chk(cap_o | 16'(flag_o) | 16'(run_o), 16'h0000);
    // Periodic count up to two, restart from zero.
    op(1, 16'h0002);
    setc(ECT_PERIPHERAL_CLOCK, ECT_MODE_PERIODIC, 1'b0);
    wait_evt();
    chk(cnt_o, 16'h0000);
    chk(16'(flag_o), 16'h0001);
    cyc(1);
    chk(cnt_o, 16'h0001);
    // Count above the compare value runs through MAX to BOTTOM.
    op(0, 16'hFFFE);
    cyc(1);
    chk(cnt_o, 16'hFFFF);
    cyc(1);
    chk(cnt_o, 16'h0000);
    // Companion ticks alone advance the count.
    setc(ECT_CLK_COMPANION, ECT_MODE_PERIODIC, 1'b0);
    op(1, 16'h00FF);
    op(0, 16'h0000);
    repeat (5) begin
      @(posedge mclk_i);
      comp_tick <= 1'b1;
      @(posedge mclk_i);
      comp_tick <= 1'b0;
    end
    cyc(3);
    chk(cnt_o, 16'h0005);
    // The divided tap gives exactly two ticks in any four cycles.
    setc(ECT_PERIPHERAL_CLOCK_DIV, ECT_MODE_PERIODIC, 1'b0);
    held = cnt_o;
    cyc(4);
    chk(cnt_o, held + 16'h0002);
    // Event capture runs freely through MAX back to BOTTOM.
    setc(ECT_PERIPHERAL_CLOCK, ECT_MODE_EVENT_CAP, 1'b0);
    op(0, 16'hFFFF);
    chk(cnt_o, 16'hFFFF);
    cyc(1);
    chk(cnt_o, 16'h0000);
    // Capture cases with a held count, so the captured value is exact.
    foreach (rows[i]) begin
      setc(ECT_CLK_NONE, rows[i].mode, rows[i].es);
      op(0, rows[i].cnt);
      op(3, 16'h0000);
      lvl(rows[i].lvl);
      wait_evt();
      chk(cap_o, rows[i].cap);
      chk(cnt_o, rows[i].after);
      op(2, 16'h0000);
      chk(16'(flag_o), 16'h0000);
    end
    // Pulse width: rise restarts without a flag, fall captures.
    setc(ECT_CLK_NONE, ECT_MODE_PW, 1'b0);
    op(0, 16'h0077);
    lvl(1'b1);
    cyc(10);
    chk(cnt_o | 16'(flag_o), 16'h0000);
    op(0, 16'h0042);
    lvl(1'b0);
    wait_evt();
    chk(cap_o, 16'h0042);
    // Time-out: rise starts, compare reached first, fall freezes.
    setc(ECT_PERIPHERAL_CLOCK, ECT_MODE_TIMEOUT, 1'b0);
    op(1, 16'h0003);
    op(3, 16'h0000);
    lvl(1'b1);
    wait_evt();
    chk(16'(run_o), 16'h0001);
    lvl(1'b0);
    cyc(10);
    chk(16'(run_o), 16'h0000);
    held = cnt_o;
    op(4, 16'h0001);
    cyc(2);
    chk(cnt_o, held);
    chk(16'(run_o), 16'h0000);
    lvl(1'b1);
    cyc(10);
    chk(16'(run_o), 16'h0001);
    // Frequency and pulse width: rise, fall captures, second rise flags.
    setc(ECT_CLK_NONE, ECT_MODE_FREQ_PW, 1'b0);
    op(3, 16'h0000);
    lvl(1'b0);
    cyc(8);
    lvl(1'b1);
    cyc(8);
    op(0, 16'h0033);
    lvl(1'b0);
    cyc(8);
    lvl(1'b1);
    wait_evt();
    chk(cap_o, 16'h0033);
    op(2, 16'h0000);
    chk(16'(flag_o), 16'h0000);
    test_done();
  end
endmodule
